// ==== hdl/pimr_defines.svh ====
// Offsets, field positions, reset values and timing counts of the mask and clock-write block
`ifndef PIMR_DEFINES_SVH
`define PIMR_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define PIMR_IDX_STAT_CONV  16'h4010
`define PIMR_IDX_STAT_GPIO  16'h4011
`define PIMR_IDX_MASK_CONV  16'h401c
`define PIMR_IDX_MASK_GPIO  16'h401d
`define PIMR_IDX_WR_CNT     16'h4020
`define PIMR_IDX_TIME_MSW   16'h4021
`define PIMR_IDX_TIME_LSW   16'h4022

// ----------------------------------------------------------------------------
// Field positions of the converter and crystal register and of the pin register
// ----------------------------------------------------------------------------
`define PIMR_BIT_HC_CONV2   9
`define PIMR_BIT_HC_CONV1   8
`define PIMR_BIT_XTAL       7
`define PIMR_BIT_UV_CONV4   3
`define PIMR_BIT_UV_CONV1   0
`define PIMR_BIT_PIN12      11
`define PIMR_BIT_PIN1       0

// ----------------------------------------------------------------------------
// Defined bits and reset values
// ----------------------------------------------------------------------------
`define PIMR_CONV_VALID     16'h038f
`define PIMR_GPIO_VALID     16'h0fff
`define PIMR_MASK_CONV_RST  16'h038f
`define PIMR_MASK_GPIO_RST  16'h0fff
`define PIMR_STAT_RST       16'h0000
`define PIMR_WR_CNT_RST     16'h0000
`define PIMR_TIME_RST       32'h0000_0000
`define PIMR_LFSR_SEED      16'hace1
`define PIMR_LFSR_TAPS      16'hb400

// ----------------------------------------------------------------------------
// Timing: one second of the seconds count at a 100 ns clock
// ----------------------------------------------------------------------------
`define PIMR_SECOND_NS      1000000000
`define PIMR_CLK_PERIOD_NS  100
`define PIMR_SEC_CYCLES     (`PIMR_SECOND_NS / `PIMR_CLK_PERIOD_NS)

`endif

// ==== hdl/pimr_pkg.sv ====
// Types shared by the mask and clock-write block
package pimr_pkg;
  typedef logic [15:0] pimr_word_t;
  typedef logic [15:0] pimr_idx_t;
  typedef logic [31:0] pimr_seconds_t;
  typedef logic [31:0] pimr_events_t;
endpackage

// ==== hdl/pimr_lfsr.sv ====
// Free-running pseudo-random source for the clock write counter
`timescale 1ns/1ps
`include "pimr_defines.svh"
module pimr_lfsr #(
  parameter logic [15:0] SEED = `PIMR_LFSR_SEED
) (
  // Clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // Random word, new every cycle
  output pimr_pkg::pimr_word_t   rnd
);
  pimr_pkg::pimr_word_t state;
  pimr_pkg::pimr_word_t next_state;

  // An all-zero seed would lock the shifter forever
  if (SEED == 16'h0000) begin : g_seed_check
    $error("pimr_lfsr: SEED must be non-zero");
  end

  // Galois shift, advances every clock so consecutive loads differ
  always_comb begin
    next_state = {1'b0, state[15:1]} ^ (state[0] ? `PIMR_LFSR_TAPS : 16'h0000);
  end

  // ----------------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= SEED;
    end else begin
      state <= next_state;
    end
  end

  assign rnd = state;
endmodule

// ==== hdl/pimr_top.sv ====
// Interrupt mask registers, event status, seconds count and clock write counter
`timescale 1ns/1ps
`include "pimr_defines.svh"
module pimr_top #(
  parameter int unsigned SEC_CYCLES = `PIMR_SEC_CYCLES
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Raw event inputs, asynchronous
  input  wire logic [1:0]  highcurrent_conv_events,
  input  wire logic        crystal_started_event,
  input  wire logic [3:0]  undervolt_conv_events,
  input  wire logic [11:0] pin_events,
  // Combined interrupt and seconds count
  output logic             irq,
  output logic [31:0]      rtc_seconds
);

  // ----------------------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------------------
  if (SEC_CYCLES < 2) begin : g_sec_check
    $error("pimr_top: SEC_CYCLES must be at least 2");
  end

  localparam pimr_pkg::pimr_events_t VALID_ALL = {`PIMR_GPIO_VALID, `PIMR_CONV_VALID};

  // ----------------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------------
  pimr_pkg::pimr_events_t  raw_all;
  pimr_pkg::pimr_events_t  sync1;
  pimr_pkg::pimr_events_t  sync2;
  pimr_pkg::pimr_events_t  sync3;
  pimr_pkg::pimr_events_t  ev_level;
  pimr_pkg::pimr_events_t  next_ev_level;
  pimr_pkg::pimr_events_t  ev_agree;
  pimr_pkg::pimr_events_t  ev_set;
  pimr_pkg::pimr_events_t  stat_all;
  pimr_pkg::pimr_events_t  next_stat_all;
  pimr_pkg::pimr_events_t  stat_clr;
  pimr_pkg::pimr_events_t  mask_all;
  pimr_pkg::pimr_word_t    mask_conv;
  pimr_pkg::pimr_word_t    mask_gpio;
  pimr_pkg::pimr_word_t    next_mask_conv;
  pimr_pkg::pimr_word_t    next_mask_gpio;
  pimr_pkg::pimr_word_t    wr_cnt;
  pimr_pkg::pimr_word_t    next_wr_cnt;
  pimr_pkg::pimr_word_t    rnd;
  pimr_pkg::pimr_seconds_t seconds;
  pimr_pkg::pimr_seconds_t next_seconds;
  logic [31:0]             presc;
  logic [31:0]             next_presc;
  logic                    tick;
  logic                    next_irq;
  logic                    wr_pend;
  logic                    next_wr_pend;
  pimr_pkg::pimr_idx_t     wr_idx;
  pimr_pkg::pimr_idx_t     next_wr_idx;
  logic [31:0]             next_hrdata;
  logic                    addr_ok;
  logic                    take;
  pimr_pkg::pimr_idx_t     a_idx;
  logic                    time_wr;
  logic [15:0]             wdata;

  // Random source for the write counter
  pimr_lfsr #(
    .SEED (`PIMR_LFSR_SEED)
  ) u_lfsr (
    .hclk    (hclk),
    .hresetn (hresetn),
    .rnd     (rnd)
  );

  // ----------------------------------------------------------------------------
  // Event synchronisers
  // ----------------------------------------------------------------------------
  // Events placed at their mask positions; pins in the upper half
  always_comb begin
    raw_all         = '0;
    raw_all[`PIMR_BIT_HC_CONV2:`PIMR_BIT_HC_CONV1] = highcurrent_conv_events;
    raw_all[`PIMR_BIT_XTAL]                        = crystal_started_event;
    raw_all[`PIMR_BIT_UV_CONV4:`PIMR_BIT_UV_CONV1] = undervolt_conv_events;
    raw_all[16 +: 12]                              = pin_events;
  end

  // A change counts only once stages two and three agree
  always_comb begin
    ev_agree      = ~(sync2 ^ sync3);
    next_ev_level = (ev_agree & sync2) | (~ev_agree & ev_level);
    ev_set        = ev_agree & sync2 & ~ev_level & VALID_ALL;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1    <= '0;
      sync2    <= '0;
      sync3    <= '0;
      ev_level <= '0;
    end else begin
      sync1    <= raw_all;
      sync2    <= sync1;
      sync3    <= sync2;
      ev_level <= next_ev_level;
    end
  end

  // ----------------------------------------------------------------------------
  // Bus address phase and write data phase
  // ----------------------------------------------------------------------------
  // Zero wait states: the slave never stalls, so hsel, htrans[1] and hready qualify a phase
  always_comb begin
    take         = hsel & htrans[1] & hready;
    a_idx        = haddr[17:2];
    addr_ok      = (haddr[31:18] == 14'h0000) && (haddr[1:0] == 2'h0);
    next_wr_pend = take & hwrite & addr_ok;
    next_wr_idx  = take ? a_idx : wr_idx;
    wdata        = hwdata[15:0];
    time_wr      = wr_pend && ((wr_idx == `PIMR_IDX_TIME_MSW) || (wr_idx == `PIMR_IDX_TIME_LSW));
  end

  // Read data is chosen in the address phase and stands in the data phase
  always_comb begin
    next_hrdata = hrdata;
    if (take && !hwrite) begin
      next_hrdata = 32'h0000_0000;
      if (addr_ok) begin
        unique case (a_idx)
          `PIMR_IDX_STAT_CONV: next_hrdata[15:0] = stat_all[15:0];
          `PIMR_IDX_STAT_GPIO: next_hrdata[15:0] = stat_all[31:16];
          `PIMR_IDX_MASK_CONV: next_hrdata[15:0] = mask_conv;
          `PIMR_IDX_MASK_GPIO: next_hrdata[15:0] = mask_gpio;
          `PIMR_IDX_WR_CNT:    next_hrdata[15:0] = wr_cnt;
          `PIMR_IDX_TIME_MSW:  next_hrdata[15:0] = seconds[31:16];
          `PIMR_IDX_TIME_LSW:  next_hrdata[15:0] = seconds[15:0];
          default:             next_hrdata     = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_idx  <= 16'h0000;
      hrdata  <= 32'h0000_0000;
    end else begin
      wr_pend <= next_wr_pend;
      wr_idx  <= next_wr_idx;
      hrdata  <= next_hrdata;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ----------------------------------------------------------------------------
  // Mask registers
  // ----------------------------------------------------------------------------
  // Undefined bits are held at zero so reads show only defined masks
  always_comb begin
    next_mask_conv = mask_conv;
    next_mask_gpio = mask_gpio;
    if (wr_pend && (wr_idx == `PIMR_IDX_MASK_CONV)) begin
      next_mask_conv = wdata & `PIMR_CONV_VALID;
    end
    if (wr_pend && (wr_idx == `PIMR_IDX_MASK_GPIO)) begin
      next_mask_gpio = wdata & `PIMR_GPIO_VALID;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_conv <= `PIMR_MASK_CONV_RST;
      mask_gpio <= `PIMR_MASK_GPIO_RST;
    end else begin
      mask_conv <= next_mask_conv;
      mask_gpio <= next_mask_gpio;
    end
  end

  // ----------------------------------------------------------------------------
  // Sticky status, write one to clear, set wins
  // ----------------------------------------------------------------------------
  assign stat_clr = {(wr_pend && (wr_idx == `PIMR_IDX_STAT_GPIO)) ? wdata : 16'h0000,
                     (wr_pend && (wr_idx == `PIMR_IDX_STAT_CONV)) ? wdata : 16'h0000};
  assign mask_all = {mask_gpio, mask_conv};

  // Latching ignores the mask so software can still poll masked events
  for (genvar i = 0; i < 32; i++) begin : g_stat
    assign next_stat_all[i] = VALID_ALL[i] & (ev_set[i] | (stat_all[i] & ~stat_clr[i]));
  end

  // Interrupt registered from next values so it matches the visible registers
  always_comb begin
    next_irq = |(next_stat_all & ~{next_mask_gpio, next_mask_conv});
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_all <= {`PIMR_STAT_RST, `PIMR_STAT_RST};
      irq      <= 1'b0;
    end else begin
      stat_all <= next_stat_all;
      irq      <= next_irq;
    end
  end

  // ----------------------------------------------------------------------------
  // Seconds count and write counter
  // ----------------------------------------------------------------------------
  // A write to either half wins over the increment in that half; the other half still takes the increment
  always_comb begin
    tick         = (presc == 32'(SEC_CYCLES - 1));
    next_presc   = tick ? 32'h0000_0000 : presc + 32'h0000_0001;
    next_seconds = tick ? seconds + 32'h0000_0001 : seconds;
    next_wr_cnt  = wr_cnt;
    if (wr_pend && (wr_idx == `PIMR_IDX_TIME_MSW)) begin
      next_seconds[31:16] = wdata;
    end
    if (wr_pend && (wr_idx == `PIMR_IDX_TIME_LSW)) begin
      next_seconds[15:0] = wdata;
    end
    if (time_wr) begin
      next_wr_cnt = rnd;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presc   <= 32'h0000_0000;
      seconds <= `PIMR_TIME_RST;
      wr_cnt  <= `PIMR_WR_CNT_RST;
    end else begin
      presc   <= next_presc;
      seconds <= next_seconds;
      wr_cnt  <= next_wr_cnt;
    end
  end

  assign rtc_seconds = seconds;

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_wr(pimr_pkg::pimr_idx_t idx);
    wr_pend && (wr_idx == idx);
  endsequence

  property p_irq_pass;
    (|(stat_all & ~mask_all)) |-> irq;
  endproperty
  a_irq_pass: assert property (p_irq_pass) else $error("unmasked status without interrupt");

  property p_irq_block;
    (ev_set != 32'h0) && ((ev_set & ~mask_all) == 32'h0) && ((stat_all & ~mask_all) == 32'h0)
      && (stat_clr == 32'h0) && !wr_pend |=> !irq;
  endproperty
  a_irq_block: assert property (p_irq_block) else $error("masked event raised interrupt");

  property p_mask_reset;
    $rose(hresetn) |-> (mask_conv == 16'h038f) && (mask_gpio == 16'h0fff);
  endproperty
  a_mask_reset: assert property (@(posedge hclk) p_mask_reset) else $error("mask reset value wrong");

  property p_conv_layout;
    s_wr(`PIMR_IDX_MASK_CONV) |=> (mask_conv == ($past(hwdata[15:0]) & 16'h038f)) ##1 $stable(mask_conv)[*1];
  endproperty
  a_conv_layout: assert property (p_conv_layout) else $error("converter mask layout wrong");

  property p_gpio_layout;
    s_wr(`PIMR_IDX_MASK_GPIO) |=> (mask_gpio == ($past(hwdata[15:0]) & 16'h0fff));
  endproperty
  a_gpio_layout: assert property (p_gpio_layout) else $error("pin mask layout wrong");

  property p_wr_cnt_load;
    time_wr |=> (wr_cnt == $past(rnd));
  endproperty
  a_wr_cnt_load: assert property (p_wr_cnt_load) else $error("write counter not reloaded");

  property p_wr_cnt_hold;
    !time_wr |=> $stable(wr_cnt);
  endproperty
  a_wr_cnt_hold: assert property (p_wr_cnt_hold) else $error("write counter changed without time write");

  property p_sec_inc;
    tick && !time_wr |=> (seconds == $past(seconds) + 32'h0000_0001);
  endproperty
  a_sec_inc: assert property (p_sec_inc) else $error("seconds did not increment");

  property p_sec_hold;
    !tick && !time_wr |=> $stable(seconds);
  endproperty
  a_sec_hold: assert property (p_sec_hold) else $error("seconds changed between ticks");

  property p_latch_masked;
    (ev_set != 32'h0) |=> ((stat_all & $past(ev_set)) == $past(ev_set));
  endproperty
  a_latch_masked: assert property (p_latch_masked) else $error("event not latched in status");

endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the interrupt mask and clock write counter block
`timescale 1ns/1ps
`include "pimr_defines.svh"

`define CHK(got, exp) \
  begin \
    checks++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end

module tb_top;
  // --------------------------------------------------------------------------
  // Parameters, byte addresses and signals
  // --------------------------------------------------------------------------
  localparam int          SEC  = 16;
  localparam logic [31:0] A_SC = {14'h0000, `PIMR_IDX_STAT_CONV, 2'h0};
  localparam logic [31:0] A_SG = {14'h0000, `PIMR_IDX_STAT_GPIO, 2'h0};
  localparam logic [31:0] A_MC = {14'h0000, `PIMR_IDX_MASK_CONV, 2'h0};
  localparam logic [31:0] A_MG = {14'h0000, `PIMR_IDX_MASK_GPIO, 2'h0};
  localparam logic [31:0] A_WC = {14'h0000, `PIMR_IDX_WR_CNT, 2'h0};
  localparam logic [31:0] A_TM = {14'h0000, `PIMR_IDX_TIME_MSW, 2'h0};
  localparam logic [31:0] A_TL = {14'h0000, `PIMR_IDX_TIME_LSW, 2'h0};
  localparam logic [31:0] A_UN = 32'h0001_00c0;

  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [18:0] ev;
  logic        irq;
  logic [31:0] rtc_seconds;
  logic [31:0] rd;
  logic [31:0] prev;
  logic [31:0] sa;
  logic [31:0] ma;
  logic [31:0] mval;
  logic [31:0] bm;
  int          pos;
  int          checks;
  int          bad_count;

  // Converter and crystal events in ev[6:0], pin events in ev[18:7]
  pimr_top #(
    .SEC_CYCLES (SEC)
  ) u_pimr_top (
    .hclk                    (hclk),
    .hresetn                 (hresetn),
    .hsel                    (hsel),
    .haddr                   (haddr),
    .htrans                  (htrans),
    .hwrite                  (hwrite),
    .hsize                   (hsize),
    .hwdata                  (hwdata),
    .hready                  (hreadyout),
    .hreadyout               (hreadyout),
    .hresp                   (hresp),
    .hrdata                  (hrdata),
    .highcurrent_conv_events (ev[6:5]),
    .crystal_started_event   (ev[4]),
    .undervolt_conv_events   (ev[3:0]),
    .pin_events              (ev[18:7]),
    .irq                     (irq),
    .rtc_seconds             (rtc_seconds)
  );

  // --------------------------------------------------------------------------
  // Clock, bus tasks and event pulse
  // --------------------------------------------------------------------------
  // Free-running 100 ns clock
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // Single word write: address phase, then data phase, each held until ready
  task automatic bus_write(input logic [31:0] a, input logic [31:0] d);
    // Start on a rising edge even when called after a negedge check
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= 1'b1;
    hsize  <= 3'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask

  // Single word read: data taken at the edge that ends the data phase
  task automatic bus_read(input logic [31:0] a, output logic [31:0] d);
    // Start on a rising edge even when called after a negedge check
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= 1'b0;
    hsize  <= 3'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    d = hrdata;
  endtask

  // Held high and low longer than the three-flop synchroniser needs
  task automatic pulse(input int i);
    ev <= 19'h1 << i;
    repeat (6) @(posedge hclk);
    ev <= 19'h0;
    repeat (6) @(posedge hclk);
  endtask

  // Verdict and end of run
  task automatic results();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Whole run is about 600 cycles; this leaves a wide margin
  initial begin
    repeat (20000) @(posedge hclk);
    bad_count++;
    results();
  end

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    checks = 0;
    bad_count = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    ev = 19'h0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Defaults, then undefined bits must not stick
    bus_read(A_MC, rd); `CHK(rd, 32'h0000_038f)
    bus_read(A_MG, rd); `CHK(rd, 32'h0000_0fff)
    `CHK(hresp, 1'b0)
    `CHK(hreadyout, 1'b1)
    bus_write(A_MC, 32'hffff_ffff);
    bus_read(A_MC, rd); `CHK(rd, 32'h0000_038f)
    bus_write(A_MG, 32'hffff_ffff);
    bus_read(A_MG, rd); `CHK(rd, 32'h0000_0fff)
    bus_read(A_UN, rd); `CHK(rd, 32'h0)
    // Every event while masked: status latches at its bit, irq stays low
    for (int i = 0; i < 19; i++) begin
      pos = (i < 4) ? i : ((i < 7) ? i + 3 : i - 7);
      sa = (i < 7) ? A_SC : A_SG;
      pulse(i);
      bus_read(sa, rd); `CHK(rd, 32'h1 << pos)
      @(negedge hclk); `CHK(irq, 1'b0)
      bus_write(sa, 32'h1 << pos);
      bus_read(sa, rd); `CHK(rd, 32'h0)
    end
    // One unmasked bit per register, at the top and bottom of the fields
    for (int k = 0; k < 2; k++) begin
      ma = k ? A_MG : A_MC;
      sa = k ? A_SG : A_SC;
      mval = k ? 32'h0000_0fff : 32'h0000_038f;
      bm = k ? 32'h1 : 32'h200;
      bus_write(ma, mval ^ bm);
      pulse(k ? 7 : 6);
      @(negedge hclk); `CHK(irq, 1'b1)
      bus_write(ma, mval);
      @(negedge hclk); `CHK(irq, 1'b0)
      bus_read(sa, rd); `CHK(rd, bm)
      bus_write(ma, mval ^ bm);
      @(negedge hclk); `CHK(irq, 1'b1)
      bus_write(sa, bm);
      @(negedge hclk); `CHK(irq, 1'b0)
      bus_write(ma, mval);
    end
    // Write counter is read-only and reloads on each time write
    bus_read(A_WC, prev); `CHK(prev, 32'h0)
    bus_write(A_WC, 32'h0000_5a5a);
    bus_read(A_WC, rd); `CHK(rd, prev)
    bus_write(A_TM, 32'h0000_0001);
    bus_read(A_WC, rd); `CHK(rd !== prev, 1'b1)
    prev = rd;
    // Seconds carry from the low half into the high half
    bus_write(A_TL, 32'h0000_ffff);
    @(negedge hclk); `CHK(rtc_seconds, 32'h0001_ffff)
    repeat (SEC) @(negedge hclk);
    `CHK(rtc_seconds, 32'h0002_0000)
    bus_read(A_TM, rd); `CHK(rd, 32'h0000_0002)
    bus_read(A_WC, rd); `CHK(rd !== prev, 1'b1)
    // Second reset mid-run brings the masks back
    bus_write(A_MC, 32'h0);
    bus_write(A_MG, 32'h0);
    hresetn <= 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus_read(A_MC, rd); `CHK(rd, 32'h0000_038f)
    bus_read(A_MG, rd); `CHK(rd, 32'h0000_0fff)
    // Well before the first tick after release, so the count is still zero
    @(negedge hclk); `CHK(rtc_seconds, 32'h0)
    `CHK(irq, 1'b0)
    results();
  end
endmodule
